/* hdl/tmr_acc_dec.sv */
// Access decoder with supervisor write protection
`timescale 1ns/10ps
module tmr_acc_dec
  import tmr_pkg::*;
(
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic [2:0]  acc_index,
  input  wire logic        acc_user,
  input  wire logic [1:0]  sup_bits,
  tmr_acc_if.dec           bus
);

  logic     prot;
  tmr_reg_t kind;
  logic     tsel;

  always_comb begin
    kind = TMR_REG_NONE;
    tsel = 1'b0;
    case (acc_index)
      TMR_IDX_MODE0:   kind = TMR_REG_MODE;
      TMR_IDX_COUNT0:  kind = TMR_REG_COUNT;
      TMR_IDX_RELOAD0: kind = TMR_REG_RELOAD;
      TMR_IDX_MODE1: begin
        kind = TMR_REG_MODE;
        tsel = 1'b1;
      end
      TMR_IDX_COUNT1: begin
        kind = TMR_REG_COUNT;
        tsel = 1'b1;
      end
      TMR_IDX_RELOAD1: begin
        kind = TMR_REG_RELOAD;
        tsel = 1'b1;
      end
      default: kind = TMR_REG_NONE;
    endcase
    prot          = sup_bits[tsel] && acc_user;
    bus.hit       = acc_req && (kind != TMR_REG_NONE);
    bus.sel_timer = tsel;
    bus.sel_reg   = kind;
    bus.read_ok   = bus.hit && !acc_write;
    bus.write_ok  = bus.hit && acc_write && !prot;
    bus.fault     = bus.hit && acc_write && prot;
  end

endmodule : tmr_acc_dec

/* hdl/tmr_acc_if.sv */
// Decoded register access passed from the decoder to the timer core
`timescale 1ns/10ps
interface tmr_acc_if;
  import tmr_pkg::*;
  logic     hit;
  logic     sel_timer;
  tmr_reg_t sel_reg;
  logic     write_ok;
  logic     read_ok;
  logic     fault;

  modport dec  (output hit, sel_timer, sel_reg, write_ok, read_ok, fault);
  modport core (input  hit, sel_timer, sel_reg, write_ok, read_ok, fault);
endinterface : tmr_acc_if

/* hdl/tmr_dual_timer.sv */
// Two independent 32-bit down-count timers with mode, count and reload registers
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////
module tmr_dual_timer
  import tmr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        sw_reset,
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic [2:0]  acc_index,
  input  wire logic [31:0] acc_wdata,
  input  wire logic        acc_user,
  output logic             acc_done,
  output logic [31:0]      acc_rdata,
  output logic             acc_fault,
  output logic [1:0]       timer_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    tmr_chan_t [TMR_NUM-1:0] chan;
    logic                    done;
    logic                    fault;
    logic [31:0]             rdata;
    logic [TMR_NUM-1:0]      irq;
  } tmr_state_t;

  tmr_state_t         st_q;
  tmr_state_t         st_d;
  logic [TMR_NUM-1:0] tick;
  logic [TMR_NUM-1:0] sup_bits;

  tmr_acc_if acc ();

  ////////////////////////////////////////////////////////////////////////////
  // Access decode and tick generators
  always_comb begin
    for (int i = 0; i < TMR_NUM; i++) begin
      sup_bits[i] = st_q.chan[i].sup;
    end
  end

  tmr_acc_dec u_dec (
    .acc_req   (acc_req),
    .acc_write (acc_write),
    .acc_index (acc_index),
    .acc_user  (acc_user),
    .sup_bits  (sup_bits),
    .bus       (acc.dec)
  );

  tmr_tick_gen u_tick0 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clr      (sw_reset),
    .csel     (st_q.chan[0].csel),
    .tick     (tick[0])
  );

  tmr_tick_gen u_tick1 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clr      (sw_reset),
    .csel     (st_q.chan[1].csel),
    .tick     (tick[1])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    tmr_chan_t c;
    logic      zero_evt;
    logic      sel;
    c        = st_q.chan[0];
    zero_evt = 1'b0;
    sel      = 1'b0;
    st_d       = st_q;
    st_d.done  = acc_req;
    st_d.fault = acc.fault;
    st_d.irq   = '0;
    if (acc_req) begin
      st_d.rdata = TMR_WORD_RST;
    end
    for (int i = 0; i < TMR_NUM; i++) begin
      c        = st_q.chan[i];
      zero_evt = 1'b0;
      sel      = acc.hit && (acc.sel_timer == 1'(i));

      // Counting, only on a selected tick while enabled
      if (c.en && tick[i]) begin
        if (c.count == TMR_COUNT_ZERO) begin
          if (c.rl) begin
            c.count = c.reload;
          end else begin
            c.en = 1'b0;
          end
        end else begin
          c.count = 32'(c.count - TMR_COUNT_ONE);
          if (c.count == TMR_COUNT_ZERO) begin
            zero_evt = 1'b1;
            if (!c.rl) begin
              c.en = 1'b0;
            end
          end
        end
      end

      // Register reads
      if (sel && acc.read_ok) begin
        case (acc.sel_reg)
          TMR_REG_MODE:   st_d.rdata = tmr_mode_word(st_q.chan[i]);
          TMR_REG_COUNT:  st_d.rdata = st_q.chan[i].count;
          TMR_REG_RELOAD: st_d.rdata = st_q.chan[i].reload;
          default:        st_d.rdata = TMR_WORD_RST;
        endcase
      end

      // Any accepted access to the mode register clears the flag
      if (sel && (acc.read_ok || acc.write_ok) && (acc.sel_reg == TMR_REG_MODE)) begin
        c.tc = 1'b0;
      end

      // Register writes, dropped when refused
      if (sel && acc.write_ok) begin
        case (acc.sel_reg)
          TMR_REG_MODE: begin
            c.en   = acc_wdata[TMR_BIT_EN];
            c.rl   = acc_wdata[TMR_BIT_RELOAD];
            c.sup  = acc_wdata[TMR_BIT_SUP];
            c.csel = acc_wdata[TMR_BIT_CSEL_HI:TMR_BIT_CSEL_LO];
          end
          TMR_REG_COUNT:  c.count  = acc_wdata;
          TMR_REG_RELOAD: c.reload = acc_wdata;
          default:        c.count  = c.count;
        endcase
      end

      // Hardware set wins over an access clear in the same cycle; soft reset wins over both
      if (zero_evt && !st_q.chan[i].rl) begin
        c.tc = 1'b1;
      end
      st_d.irq[i] = zero_evt;

      if (sw_reset) begin
        c.tc   = 1'b0;
        c.en   = 1'b0;
        c.rl   = 1'b0;
        c.sup  = 1'b0;
        c.csel = TMR_CSEL_RST;
      end
      st_d.chan[i] = c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < TMR_NUM; i++) begin
        st_q.chan[i].tc     <= 1'b0;
        st_q.chan[i].en     <= 1'b0;
        st_q.chan[i].rl     <= 1'b0;
        st_q.chan[i].sup    <= 1'b0;
        st_q.chan[i].csel   <= TMR_CSEL_RST;
        st_q.chan[i].count  <= TMR_WORD_RST;
        st_q.chan[i].reload <= TMR_WORD_RST;
      end
      st_q.done  <= 1'b0;
      st_q.fault <= 1'b0;
      st_q.rdata <= TMR_WORD_RST;
      st_q.irq   <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign acc_done  = st_q.done;
  assign acc_rdata = st_q.rdata;
  assign acc_fault = st_q.fault;
  assign timer_irq = st_q.irq;

endmodule : tmr_dual_timer

/* hdl/tmr_pkg.sv */
// Shared constants, types and helpers for the dual down-count timer
package tmr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices on the access port (byte address is index times four)
  localparam logic [2:0]  TMR_IDX_MODE0   = 3'h0;
  localparam logic [2:0]  TMR_IDX_COUNT0  = 3'h1;
  localparam logic [2:0]  TMR_IDX_RELOAD0 = 3'h2;
  localparam logic [2:0]  TMR_IDX_MODE1   = 3'h3;
  localparam logic [2:0]  TMR_IDX_COUNT1  = 3'h4;
  localparam logic [2:0]  TMR_IDX_RELOAD1 = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register field positions
  localparam int          TMR_BIT_TC      = 0;
  localparam int          TMR_BIT_EN      = 1;
  localparam int          TMR_BIT_RELOAD  = 2;
  localparam int          TMR_BIT_SUP     = 3;
  localparam int          TMR_BIT_CSEL_LO = 4;
  localparam int          TMR_BIT_CSEL_HI = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and count constants
  localparam logic [31:0] TMR_WORD_RST    = 32'h0000_0000;
  localparam logic [1:0]  TMR_CSEL_RST    = 2'h0;
  localparam logic [2:0]  TMR_DIV_RST     = 3'h0;
  localparam logic [31:0] TMR_COUNT_ONE   = 32'h0000_0001;
  localparam logic [31:0] TMR_COUNT_ZERO  = 32'h0000_0000;
  localparam int          TMR_NUM         = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    TMR_REG_MODE,
    TMR_REG_COUNT,
    TMR_REG_RELOAD,
    TMR_REG_NONE
  } tmr_reg_t;

  typedef struct packed {
    logic        tc;
    logic        en;
    logic        rl;
    logic        sup;
    logic [1:0]  csel;
    logic [31:0] count;
    logic [31:0] reload;
  } tmr_chan_t;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [2:0] tmr_div_mask(input logic [1:0] csel);
    case (csel)
      2'h0:    tmr_div_mask = 3'h0;
      2'h1:    tmr_div_mask = 3'h1;
      2'h2:    tmr_div_mask = 3'h3;
      default: tmr_div_mask = 3'h7;
    endcase
  endfunction : tmr_div_mask

  function automatic logic [31:0] tmr_mode_word(input tmr_chan_t c);
    logic [31:0] w;
    w                                 = TMR_WORD_RST;
    w[TMR_BIT_TC]                     = c.tc;
    w[TMR_BIT_EN]                     = c.en;
    w[TMR_BIT_RELOAD]                 = c.rl;
    w[TMR_BIT_SUP]                    = c.sup;
    w[TMR_BIT_CSEL_HI:TMR_BIT_CSEL_LO] = c.csel;
    tmr_mode_word                     = w;
  endfunction : tmr_mode_word

endpackage : tmr_pkg

/* hdl/tmr_tick_gen.sv */
// Divided tick enable derived from the bus clock
`timescale 1ns/10ps
module tmr_tick_gen
  import tmr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic [1:0]  csel,
  output logic             tick
);

  typedef struct packed {
    logic [2:0] cnt;
  } tmr_tick_state_t;

  tmr_tick_state_t st_q;
  tmr_tick_state_t st_d;

  always_comb begin
    st_d     = st_q;
    st_d.cnt = clr ? TMR_DIV_RST : 3'(st_q.cnt + 3'h1);
  end

  // Tick every 1, 2, 4 or 8 bus clocks
  assign tick = ((st_q.cnt & tmr_div_mask(csel)) == tmr_div_mask(csel));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q.cnt <= TMR_DIV_RST;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : tmr_tick_gen

/* sim/test_dual_downcount_timer_control.sv */
// Self-checking bench for the dual down-count timer
`timescale 1ns/10ps
module test_dual_downcount_timer_control
  import tmr_pkg::*;
;
  logic        core_clk, rst_n, sw_reset, acc_req, acc_write, acc_user, acc_done, acc_fault;
  logic [2:0]  acc_index;
  logic [31:0] acc_wdata, acc_rdata, seen;
  logic [1:0]  timer_irq;
  logic [64:0] expq [$];
  int          mismatches, n_tests, irq0, irq1;

  tmr_dual_timer i_tmr_dual_timer (.core_clk(core_clk), .rst_n(rst_n), .sw_reset(sw_reset),
    .acc_req(acc_req), .acc_write(acc_write), .acc_index(acc_index), .acc_wdata(acc_wdata),
    .acc_user(acc_user), .acc_done(acc_done), .acc_rdata(acc_rdata), .acc_fault(acc_fault),
    .timer_irq(timer_irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Answer watcher: oldest note against each acc_done
  always @(posedge core_clk) begin : watch
    logic [64:0] e;
    irq0 += int'(timer_irq[0] === 1'b1);
    irq1 += int'(timer_irq[1] === 1'b1);
    if (acc_done === 1'b1) begin
      seen = acc_rdata;
      if (expq.size() == 0) begin
        check("acc_done", 32'h0, 32'h1);
      end else begin
        e = expq.pop_front();
        check("acc_rdata", e[32:1], acc_rdata & e[64:33]);
        check("acc_fault", {31'h0, e[0]}, {31'h0, acc_fault});
      end
    end
  end

  task automatic acc(input logic wr, input logic [2:0] idx, input logic [31:0] d, input logic usr,
                     input logic [31:0] exp, input logic [31:0] msk, input logic flt);
    @(posedge core_clk);
    #1;
    acc_req = 1'b1;
    acc_write = wr;
    acc_index = idx;
    acc_wdata = d;
    acc_user = usr;
    expq.push_back({msk, exp & msk, flt});
    @(posedge core_clk);
    #1;
    acc_req = 1'b0;
    @(posedge core_clk);
    #1;
    if (expq.size() != 0) begin
      mismatches++;
      end_of_test();
    end
  endtask : acc

  task automatic wr(input logic [2:0] idx, input logic [31:0] d, input logic usr = 1'b0,
                    input logic flt = 1'b0);
    acc(1'b1, idx, d, usr, 32'h0, 32'hFFFF_FFFF, flt);
  endtask : wr

  task automatic rd(input logic [2:0] idx, input logic [31:0] exp, input logic [31:0] msk = 32'hFFFF_FFFF);
    acc(1'b0, idx, $urandom(), 1'($urandom_range(1)), exp, msk, 1'b0);
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    int          n;
    {rst_n, sw_reset, acc_req, acc_write, acc_user, acc_index, acc_wdata} = '0;
    {mismatches, n_tests, irq0, irq1} = '0;
    void'($urandom(39028));
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) rd(i[2:0], 32'h0);
    wr(3'h7, $urandom(), 1'b1);
    r = $urandom();
    wr(TMR_IDX_RELOAD1, r);
    rd(TMR_IDX_RELOAD1, r);
    // Single shot with a stray reload value and the flag bit written
    wr(TMR_IDX_RELOAD0, 32'h0000_0007);
    wr(TMR_IDX_COUNT0, 32'h0000_0005);
    wr(TMR_IDX_MODE0, 32'h0000_0003);
    repeat (20) @(posedge core_clk);
    rd(TMR_IDX_MODE0, 32'h0000_0001);
    rd(TMR_IDX_MODE0, 32'h0000_0000);
    wr(TMR_IDX_MODE0, 32'h0000_0001);
    rd(TMR_IDX_MODE0, 32'h0000_0000);
    rd(TMR_IDX_COUNT0, 32'h0000_0000);
    check("irq0", 32'h1, irq0);
    // Tick rate for each select value, then stop and hold
    for (int c = 0; c < 4; c++) begin
      wr(TMR_IDX_COUNT1, 32'h0000_1000 + $urandom_range(255));
      wr(TMR_IDX_MODE1, {26'h0, c[1:0], 4'h2});
      rd(TMR_IDX_COUNT1, 32'h0, 32'h0);
      r = seen;
      repeat (61) @(posedge core_clk);
      rd(TMR_IDX_COUNT1, 32'h0, 32'h0);
      check("ticks", 32'd64 >> c, r - seen);
      wr(TMR_IDX_MODE1, 32'h0);
      rd(TMR_IDX_COUNT1, 32'h0, 32'h0);
      r = seen;
      repeat (20) @(posedge core_clk);
      rd(TMR_IDX_COUNT1, r);
    end
    // Auto reload, flag masked while running, then soft reset
    irq0 = 0;
    wr(TMR_IDX_RELOAD0, 32'h0000_0003);
    wr(TMR_IDX_COUNT0, 32'h0000_0002);
    wr(TMR_IDX_MODE0, 32'h0000_0006);
    repeat (40) @(posedge core_clk);
    rd(TMR_IDX_MODE0, 32'h0000_0006, 32'hFFFF_FFFE);
    check("reloads", 32'h1, 32'(irq0 >= 8));
    @(posedge core_clk);
    #1;
    sw_reset = 1'b1;
    @(posedge core_clk);
    #1;
    sw_reset = 1'b0;
    rd(TMR_IDX_MODE0, 32'h0);
    n = irq0;
    repeat (20) @(posedge core_clk);
    check("irq0 after reset", n, irq0);
    // Write protection on timer 1
    wr(TMR_IDX_MODE1, 32'h0000_0008);
    wr(TMR_IDX_COUNT1, 32'h0000_0055, 1'b1, 1'b1);
    wr(TMR_IDX_RELOAD1, 32'h0000_0066, 1'b1, 1'b1);
    wr(TMR_IDX_MODE1, 32'h0000_0000, 1'b1, 1'b1);
    rd(TMR_IDX_MODE1, 32'h0000_0008);
    wr(TMR_IDX_COUNT1, 32'h0000_0077);
    rd(TMR_IDX_COUNT1, 32'h0000_0077);
    wr(TMR_IDX_MODE1, 32'h0000_0000);
    wr(TMR_IDX_COUNT1, 32'h0000_0099, 1'b1);
    rd(TMR_IDX_COUNT1, 32'h0000_0099);
    // Protected single shot on timer 1; a refused write keeps the flag
    wr(TMR_IDX_COUNT1, 32'h0000_0003);
    wr(TMR_IDX_MODE1, 32'h0000_000A);
    repeat (10) @(posedge core_clk);
    wr(TMR_IDX_MODE1, 32'h0000_0000, 1'b1, 1'b1);
    rd(TMR_IDX_MODE1, 32'h0000_0009);
    check("irq1", 32'h1, irq1);
    end_of_test();
  end
endmodule : test_dual_downcount_timer_control

/* sim/tmr_dual_timer_properties.sv */
// Port-level checker for the dual down-count timer
`timescale 1ns/10ps
module tmr_dual_timer_chk
  import tmr_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        sw_reset,
  input wire logic        acc_req,
  input wire logic        acc_write,
  input wire logic [2:0]  acc_index,
  input wire logic        acc_user,
  input wire logic        acc_done,
  input wire logic [31:0] acc_rdata,
  input wire logic        acc_fault,
  input wire logic [1:0]  timer_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  property p_read_ok; acc_req && !acc_write |=> acc_done && !acc_fault; endproperty
  a_read_ok: assert property (p_read_ok) else $error("read not answered cleanly");
  property p_idle; !acc_req |=> !acc_done && !acc_fault && $stable(acc_rdata); endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_wr_zero; acc_req && acc_write |=> acc_done && acc_rdata == TMR_WORD_RST; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer wrong");
  property p_fault_cause; acc_fault |-> $past(acc_req && acc_write && acc_user); endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("fault without user write");
  property p_sup_ok; acc_req && acc_write && !acc_user |=> !acc_fault; endproperty
  a_sup_ok: assert property (p_sup_ok) else $error("supervisor write faulted");
  property p_unmap; acc_req && acc_index > TMR_IDX_RELOAD1 |=> acc_rdata == TMR_WORD_RST && !acc_fault;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access wrong");
  property p_irq_pulse; timer_irq != 2'h0 |=> (timer_irq & $past(timer_irq)) == 2'h0; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a cycle");
  property p_sw_stop; sw_reset ##1 !(acc_req && acc_write) |=> (timer_irq == 2'h0) [*2]; endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("timer ran after soft reset");
endmodule : tmr_dual_timer_chk

bind tmr_dual_timer tmr_dual_timer_chk i_tmr_dual_timer_chk (.core_clk(core_clk), .rst_n(rst_n),
  .sw_reset(sw_reset), .acc_req(acc_req), .acc_write(acc_write), .acc_index(acc_index),
  .acc_user(acc_user), .acc_done(acc_done), .acc_rdata(acc_rdata), .acc_fault(acc_fault),
  .timer_irq(timer_irq));
